// ### verilog/oamie_pkg.sv
// Purpose: Shared types and constants for the four-instruction execute slice.
// Assumes: 14-bit instruction words, 8-bit data path, 7-bit file addresses.
// Notes: Opcode patterns are matched on the top bits of the instruction word.
package oamie_pkg;

    // Data path and field widths.
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int INSTR_W = 14;

    // Field positions inside the instruction word.
    localparam int LIT_LSB = 0;
    localparam int ADDR_LSB = 0;
    localparam int DEST_BIT = 7;
    localparam int OPC6_LSB = 8;
    localparam int OPC4_LSB = 10;

    // Opcode patterns; the load-literal form only checks four bits.
    localparam logic [5:0] OPC_OR_LIT = 6'h38;
    localparam logic [5:0] OPC_OR_FILE = 6'h04;
    localparam logic [5:0] OPC_COPY_FILE = 6'h08;
    localparam logic [3:0] OPC_LOAD_LIT = 4'hc;

    // Destination choice encoding.
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    // Reset values.
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;

    // Timing: one instruction cycle is four clock periods at 100 ns each.
    localparam int CLK_PERIOD_NS = 100;
    localparam int PHASES_PER_CYCLE = 4;
    localparam int INSTR_CYCLE_NS = CLK_PERIOD_NS * PHASES_PER_CYCLE;

    // Phases of one instruction cycle.
    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } oamie_phase_e;

    // Operations that this slice executes.
    typedef enum logic [2:0] {
        OP_NONE,
        OP_OR_LIT,
        OP_OR_FILE,
        OP_LOAD_LIT,
        OP_COPY_FILE
    } oamie_op_e;

    // Decoded instruction held through the cycle.
    typedef struct packed {
        oamie_op_e op;
        logic dest;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] lit;
    } oamie_dec_s;

    // Register-file write port.
    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } oamie_fwr_s;

endpackage

// ### verilog/oamie_phase_gen.sv
// Purpose: Four-phase sequencer that splits the core clock into Q1..Q4.
// Assumes: Synchronous active-high reset; one phase per clock.
// Notes: Restarts at Q1 after reset so a new instruction is decoded first.
`timescale 1ns/1ps

module oamie_phase_gen (
    input wire logic clk,
    input wire logic rst,
    output oamie_pkg::oamie_phase_e phase
);
    import oamie_pkg::*;

    oamie_phase_e phase_reg;
    oamie_phase_e phase_next;

    // Advance one phase per clock, wrapping from Q4 back to Q1.
    always_comb begin
        case (phase_reg)
            PH_Q1: phase_next = PH_Q2;
            PH_Q2: phase_next = PH_Q3;
            PH_Q3: phase_next = PH_Q4;
            default: phase_next = PH_Q1;
        endcase
    end

    // Phase register.
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_reg <= PH_Q1;
        end else begin
            phase_reg <= phase_next;
        end
    end

    assign phase = phase_reg;

endmodule

// ### verilog/oamie_exec.sv
// Purpose: Decode and execute OR-literal, OR-with-file, load-literal and copy-file.
// Assumes: instr_word is valid in Q1; file_rd_data answers file_rd_addr within Q2.
// Notes: Any other opcode runs as a no-operation; nothing is written.
`timescale 1ns/1ps

// Summary of operation
// - OR-literal ORs the immediate into the accumulator and updates zero.
// - The immediate is the unsigned low byte of the instruction, 0 to 255.
// - Load-literal puts the immediate in the accumulator; don't-care bits ignored.
// - Copy-file reads the addressed file and writes it unchanged to the target.
// - Copy-file choice bit 0 targets the accumulator, 1 the same file register.
// - Copy-file updates zero from the moved value, giving a zero test.
// - File addresses are seven bits, 0 to 127; the choice bit is one bit.
module oamie_exec (
    input wire logic clk,
    input wire logic rst,
    input wire logic [oamie_pkg::INSTR_W-1:0] instr_word,
    input wire logic [oamie_pkg::DATA_W-1:0] file_rd_data,
    output oamie_pkg::oamie_phase_e phase,
    output logic [oamie_pkg::ADDR_W-1:0] file_rd_addr,
    output oamie_pkg::oamie_fwr_s file_wr,
    output logic [oamie_pkg::DATA_W-1:0] acc,
    output logic zero_flag
);
    import oamie_pkg::*;

    oamie_phase_e phase_cur;
    oamie_dec_s dec_reg;
    oamie_dec_s dec_next;
    logic [ADDR_W-1:0] rd_addr_reg;
    logic [ADDR_W-1:0] rd_addr_next;
    logic [DATA_W-1:0] operand_reg;
    logic [DATA_W-1:0] operand_next;
    logic [DATA_W-1:0] result_reg;
    logic [DATA_W-1:0] result_next;
    oamie_fwr_s fwr_reg;
    oamie_fwr_s fwr_next;
    logic [DATA_W-1:0] acc_reg;
    logic [DATA_W-1:0] acc_next;
    logic zero_reg;
    logic zero_next;

    oamie_phase_gen u_phase (
        .clk(clk),
        .rst(rst),
        .phase(phase_cur)
    );

    // Decode in Q1; the read address is registered so the file sees it during Q2.
    always_comb begin
        dec_next = dec_reg;
        rd_addr_next = rd_addr_reg;
        if (phase_cur == PH_Q1) begin
            dec_next.lit = instr_word[LIT_LSB +: DATA_W];
            dec_next.addr = instr_word[ADDR_LSB +: ADDR_W];
            dec_next.dest = instr_word[DEST_BIT];
            rd_addr_next = instr_word[ADDR_LSB +: ADDR_W];
            // Bits 9:8 of load-literal are don't-care, so only four bits match.
            if (instr_word[OPC6_LSB +: 6] == OPC_OR_LIT) begin
                dec_next.op = OP_OR_LIT;
            end else if (instr_word[OPC4_LSB +: 4] == OPC_LOAD_LIT) begin
                dec_next.op = OP_LOAD_LIT;
            end else if (instr_word[OPC6_LSB +: 6] == OPC_OR_FILE) begin
                dec_next.op = OP_OR_FILE;
            end else if (instr_word[OPC6_LSB +: 6] == OPC_COPY_FILE) begin
                dec_next.op = OP_COPY_FILE;
            end else begin
                dec_next.op = OP_NONE;
            end
        end
    end

    // Decode state.
    always_ff @(posedge clk) begin
        if (rst) begin
            dec_reg <= '{op: OP_NONE, dest: DEST_ACC, addr: '0, lit: '0};
            rd_addr_reg <= '0;
        end else begin
            dec_reg <= dec_next;
            rd_addr_reg <= rd_addr_next;
        end
    end

    // Q2 fetches the operand, Q3 forms the result and stages the file write.
    always_comb begin
        operand_next = operand_reg;
        result_next = result_reg;
        fwr_next = fwr_reg;
        fwr_next.en = 1'b0;
        if (phase_cur == PH_Q2) begin
            if (dec_reg.op == OP_OR_FILE || dec_reg.op == OP_COPY_FILE) begin
                operand_next = file_rd_data;
            end else begin
                operand_next = dec_reg.lit;
            end
        end
        if (phase_cur == PH_Q3) begin
            case (dec_reg.op)
                OP_OR_LIT: result_next = acc_reg | operand_reg;
                OP_OR_FILE: result_next = acc_reg | operand_reg;
                OP_COPY_FILE: result_next = operand_reg;
                default: result_next = operand_reg;
            endcase
            // The write is staged here so the port shows it for all of Q4.
            fwr_next.addr = dec_reg.addr;
            fwr_next.en = (dec_reg.op == OP_OR_FILE || dec_reg.op == OP_COPY_FILE)
                && dec_reg.dest == DEST_FILE;
            if (dec_reg.op == OP_COPY_FILE) begin
                fwr_next.data = operand_reg;
            end else begin
                fwr_next.data = acc_reg | operand_reg;
            end
        end
    end

    // Datapath state.
    always_ff @(posedge clk) begin
        if (rst) begin
            operand_reg <= '0;
            result_reg <= '0;
            fwr_reg <= '0;
        end else begin
            operand_reg <= operand_next;
            result_reg <= result_next;
            fwr_reg <= fwr_next;
        end
    end

    // Q4 commits the accumulator and the zero flag.
    always_comb begin
        acc_next = acc_reg;
        zero_next = zero_reg;
        if (phase_cur == PH_Q4) begin
            case (dec_reg.op)
                OP_OR_LIT: begin
                    acc_next = result_reg;
                    zero_next = (result_reg == '0);
                end
                OP_OR_FILE: begin
                    if (dec_reg.dest == DEST_ACC) begin
                        acc_next = result_reg;
                    end
                    zero_next = (result_reg == '0);
                end
                OP_COPY_FILE: begin
                    if (dec_reg.dest == DEST_ACC) begin
                        acc_next = result_reg;
                    end
                    // Writing a register onto itself still sets zero: a cheap test.
                    zero_next = (result_reg == '0);
                end
                OP_LOAD_LIT: begin
                    acc_next = result_reg;
                end
                default: begin
                    acc_next = acc_reg;
                end
            endcase
        end
    end

    // Architectural state.
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_reg <= ACC_RESET;
            zero_reg <= ZERO_RESET;
        end else begin
            acc_reg <= acc_next;
            zero_reg <= zero_next;
        end
    end

    assign phase = phase_cur;
    assign file_rd_addr = rd_addr_reg;
    assign file_wr = fwr_reg;
    assign acc = acc_reg;
    assign zero_flag = zero_reg;

    // Checks: an instruction starts at Q1; its file write is judged three clocks later in Q4, its results four.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic q1_or_lit;
    logic q1_load;
    logic q1_or_file;
    logic q1_copy;
    assign q1_or_lit = phase_cur == PH_Q1 && instr_word[13:8] == OPC_OR_LIT;
    assign q1_load = phase_cur == PH_Q1 && instr_word[13:10] == OPC_LOAD_LIT;
    assign q1_or_file = phase_cur == PH_Q1 && instr_word[13:8] == OPC_OR_FILE;
    assign q1_copy = phase_cur == PH_Q1 && instr_word[13:8] == OPC_COPY_FILE;

    property p_or_lit;
        q1_or_lit |-> ##4 acc == ($past(acc, 4) | $past(instr_word[7:0], 4))
            && zero_flag == (acc == 8'h00);
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("OR literal result wrong");

    // The strobe is checked in Q4 itself, where a wrong write would show.
    property p_or_file_acc;
        q1_or_file && !instr_word[7] |-> ##3 !file_wr.en
            ##1 acc == ($past(acc, 4) | $past(file_rd_data, 3));
    endproperty
    a_or_file_acc: assert property (p_or_file_acc) else $error("OR file to acc wrong");

    property p_or_file_back;
        q1_or_file && instr_word[7] |-> ##3 file_wr.en
            && file_wr.data == ($past(acc, 3) | $past(file_rd_data, 2))
            && file_wr.addr == $past(instr_word[6:0], 3) ##1 $stable(acc);
    endproperty
    a_or_file_back: assert property (p_or_file_back) else $error("OR write wrong");

    property p_load;
        q1_load |-> ##4 acc == $past(instr_word[7:0], 4) && $stable(zero_flag);
    endproperty
    a_load: assert property (p_load) else $error("Load literal wrong");

    property p_copy_acc;
        q1_copy && !instr_word[7] |-> ##4 acc == $past(file_rd_data, 3);
    endproperty
    a_copy_acc: assert property (p_copy_acc) else $error("Copy to acc wrong");

    property p_copy_back;
        q1_copy && instr_word[7] |-> ##3 file_wr.en && file_wr.data == $past(file_rd_data, 2)
            ##1 $stable(acc);
    endproperty
    a_copy_back: assert property (p_copy_back) else $error("Copy write back wrong");

    property p_copy_zero;
        q1_copy |-> ##4 zero_flag == ($past(file_rd_data, 3) == 8'h00);
    endproperty
    a_copy_zero: assert property (p_copy_zero) else $error("Copy zero flag wrong");

    property p_rd_addr;
        phase_cur == PH_Q1 |=> file_rd_addr == $past(instr_word[6:0]);
    endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("Read address wrong");

    property p_phases;
        phase_cur == PH_Q1 |=> phase_cur == PH_Q2 ##1 phase_cur == PH_Q3
            ##1 phase_cur == PH_Q4 ##1 phase_cur == PH_Q1;
    endproperty
    a_phases: assert property (p_phases) else $error("Phase order broken");

    property p_write_q4;
        file_wr.en |-> phase_cur == PH_Q4;
    endproperty
    a_write_q4: assert property (p_write_q4) else $error("File write outside Q4");

    c_or_lit_zero: cover property (q1_or_lit ##4 zero_flag);
    c_or_file_back: cover property (q1_or_file && instr_word[7] ##3 file_wr.en);
    c_copy_test: cover property (q1_copy && instr_word[7] ##4 zero_flag);
    c_load: cover property (q1_load ##4 acc != 8'h00);

endmodule

// ### testbench/oamie_exec_bench.sv
// Purpose: Self-checking bench for the four-instruction execute slice.
// Assumes: One instruction per four clocks; read data is held for the whole cycle.
// Notes: A small reference model in the bench predicts the accumulator, flag and writes.
`timescale 1ns/1ps

module oamie_exec_bench;
    import oamie_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [INSTR_W-1:0] instr_word = '0;
    logic [DATA_W-1:0] file_rd_data = '0;
    oamie_phase_e phase;
    logic [ADDR_W-1:0] file_rd_addr;
    oamie_fwr_s file_wr;
    logic [DATA_W-1:0] acc;
    logic zero_flag;
    int n_errors = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'h5ab15a47;
    logic [DATA_W-1:0] exp_acc = ACC_RESET;
    logic exp_zero = ZERO_RESET;

    // An opcode outside the four handled ones; it must behave as a no-operation.
    localparam logic [5:0] OPC_OTHER = 6'h0f;

    // The clock runs at 10 MHz.
    always #50 clk = ~clk;

    oamie_exec dut_u (
        .clk(clk),
        .rst(rst),
        .instr_word(instr_word),
        .file_rd_data(file_rd_data),
        .phase(phase),
        .file_rd_addr(file_rd_addr),
        .file_wr(file_wr),
        .acc(acc),
        .zero_flag(zero_flag)
    );

    // Shift register step for repeatable random stimulus.
    function automatic logic [31:0] lfsr_step(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Compares a bus value; case inequality so an unknown never matches.
    task automatic check_val(input string name, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    // Compares a single flag or strobe.
    task automatic check_bit(input string name, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", name, e, g);
        end
    endtask

    // Runs one instruction cycle; entered in the time step of the edge starting Q1.
    // Results of the previous instruction are checked first, since they land on that edge.
    task automatic run_instr(input logic [INSTR_W-1:0] w, input logic [DATA_W-1:0] rd);
        logic [5:0] opc;
        logic [DATA_W-1:0] res;
        logic [DATA_W-1:0] old_acc;
        logic wr_due;
        logic file_op;
        instr_word <= w;
        file_rd_data <= rd;
        #1;
        check_val("phase", 16'(PH_Q1), 16'(phase));
        check_val("acc", 16'(exp_acc), 16'(acc));
        check_bit("zero_flag", exp_zero, zero_flag);
        opc = w[13:8];
        old_acc = exp_acc;
        wr_due = 1'b0;
        file_op = (opc == OPC_OR_FILE) || (opc == OPC_COPY_FILE);
        res = exp_acc | w[7:0];
        if (opc == OPC_OR_LIT) begin
            exp_acc = res;
            exp_zero = (res == 8'h00);
        end else if (opc[5:2] == OPC_LOAD_LIT) begin
            exp_acc = w[7:0];
        end else if (file_op) begin
            res = (opc == OPC_OR_FILE) ? (exp_acc | rd) : rd;
            exp_zero = (res == 8'h00);
            if (w[DEST_BIT] == DEST_FILE) begin
                wr_due = 1'b1;
            end else begin
                exp_acc = res;
            end
        end
        @(posedge clk);
        #1;
        if (file_op) begin
            check_val("file_rd_addr", 16'(w[6:0]), 16'(file_rd_addr));
        end
        check_bit("file_wr_en_q2", 1'b0, file_wr.en);
        repeat (2) @(posedge clk);
        #1;
        check_bit("file_wr_en_q4", wr_due, file_wr.en);
        check_val("acc_before_q4_end", 16'(old_acc), 16'(acc));
        if (wr_due) begin
            check_val("file_wr_addr", 16'(w[6:0]), 16'(file_wr.addr));
            check_val("file_wr_data", 16'(res), 16'(file_wr.data));
        end
        @(posedge clk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // A hang is cut short well after the expected run of under a thousand clocks.
    initial begin
        #(3000 * CLK_PERIOD_NS);
        n_errors++;
        give_verdict();
    end

    // Corner cases first, then random traffic over the four handled opcodes and OPC_OTHER, then a second reset.
    initial begin
        logic [5:0] opc;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        run_instr({OPC_OR_LIT, 8'h00}, 8'h5a);
        run_instr({OPC_LOAD_LIT, 2'b11, 8'h9a}, 8'h00);
        run_instr({OPC_OR_LIT, 8'hbf}, 8'h00);
        run_instr({OPC_LOAD_LIT, 2'b00, 8'h00}, 8'h77);
        run_instr({OPC_OR_FILE, DEST_FILE, 7'h7f}, 8'h00);
        run_instr({OPC_OR_FILE, DEST_ACC, 7'h00}, 8'h93);
        run_instr({OPC_COPY_FILE, DEST_FILE, 7'h7f}, 8'h00);
        run_instr({OPC_COPY_FILE, DEST_ACC, 7'h2a}, 8'hff);
        run_instr({OPC_OTHER, 8'h81}, 8'h00);
        run_instr({OPC_OR_LIT, 8'hff}, 8'h00);
        for (int i = 0; i < 200; i++) begin
            seed = lfsr_step(seed);
            seed = lfsr_step(seed);
            case (seed[26:24] % 5)
                0: opc = OPC_OR_LIT;
                1: opc = OPC_OR_FILE;
                2: opc = OPC_COPY_FILE;
                3: opc = {OPC_LOAD_LIT, seed[29:28]};
                default: opc = OPC_OTHER;
            endcase
            run_instr({opc, seed[7:0]}, seed[15:8]);
        end
        // Leave a non-reset accumulator and a set zero flag, so the reset is visible.
        run_instr({OPC_LOAD_LIT, 2'b00, 8'h5a}, 8'h00);
        run_instr({OPC_COPY_FILE, DEST_FILE, 7'h11}, 8'h00);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        exp_acc = ACC_RESET;
        exp_zero = ZERO_RESET;
        run_instr({OPC_OR_LIT, 8'h00}, 8'h00);
        run_instr(14'h0000, 8'h00);
        give_verdict();
    end

endmodule
